// ===== design/lcdc_map.svh
// Purpose: Offsets, field positions, reset values and timing for the crossing detector
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Definitions only
`ifndef LCDC_MAP_SVH
`define LCDC_MAP_SVH
// ----------------------------------------------------------------------
// Instance base and register byte offsets
// ----------------------------------------------------------------------
`define LCDC_BASE 32'h4001_3000
`define LCDC_BASE_MASK 32'hffff_f000
`define LCDC_OFS_BEGIN 12'h000
`define LCDC_OFS_HALT 12'h004
`define LCDC_OFS_CAPTURE 12'h008
`define LCDC_OFS_VALID 12'h100
`define LCDC_OFS_FALLING 12'h104
`define LCDC_OFS_RISING 12'h108
`define LCDC_OFS_ANYCROSS 12'h10c
`define LCDC_OFS_LINKS 12'h200
`define LCDC_OFS_MASK 12'h300
`define LCDC_OFS_MASK_SET 12'h304
`define LCDC_OFS_MASK_CLR 12'h308
`define LCDC_OFS_OUTCOME 12'h400
`define LCDC_OFS_ENABLE 12'h500
`define LCDC_OFS_PSEL 12'h504
`define LCDC_OFS_REFSRC 12'h508
`define LCDC_OFS_REFPIN 12'h50c
`define LCDC_OFS_LADDER 12'h530
`define LCDC_OFS_CONFIG 12'h534
`define LCDC_OFS_BAND 12'h538
// ----------------------------------------------------------------------
// Field positions, values and timing
// ----------------------------------------------------------------------
`define LCDC_ENABLE_ON 2'h2
`define LCDC_LADDER_UP_LSB 8
`define LCDC_CONFIG_MAIN_BIT 8
`define LCDC_RESET_WORD 32'h0000_0000
`define LCDC_T_START_NS 32'd1000
`define LCDC_CLK_NS 32'd40
`define LCDC_RESP_OKAY 2'h0
`define LCDC_RESP_SLVERR 2'h2
`endif

// ===== design/lcdc_pkg.sv
// Purpose: Types shared by the crossing detector files
// Assumes: Constants live in lcdc_map.svh
// Notes:   Types only
package lcdc_pkg;
  // Activity of the detector
  typedef enum logic [1:0] {LCDC_IDLE, LCDC_STARTING, LCDC_RUNNING} lcdc_state_t;
  // Register write request handed from the bus slave
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } lcdc_wreq_t;
  // Controls driven towards the analog core
  typedef struct packed {
    logic powered;
    logic [2:0] pos_sel;
    logic [2:0] ref_src;
    logic [2:0] ref_pin;
    logic single_ended;
    logic [1:0] speed;
    logic band_en;
    logic [5:0] ladder_code;
  } lcdc_ana_ctl_t;
endpackage

// ===== design/lcdc_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the crossing detector registers
// Assumes: One write and one read outstanding at most
// Notes:   Write pulse in the cycle both halves are held; read data one cycle after AR
`timescale 1ns/1ps
module lcdc_axil_slave
  import lcdc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output lcdc_wreq_t wreq_o,
  output logic wr_o,
  input wire logic wr_err_i,
  output logic rd_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);
  `include "lcdc_map.svh"
  logic aw_have_q; // Address half held
  logic w_have_q; // Data half held
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  lcdc_wreq_t wreq_q; // Collected write request

  // Each half is taken only while its slot is free and no response waits
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_o = aw_have_q && w_have_q && !bvalid_q;
  assign rd_o = s_axi_arvalid && s_axi_arready;
  assign wreq_o = wreq_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Write channel: collect halves in either order, then answer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `LCDC_RESP_OKAY;
      wreq_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        wreq_q.addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wreq_q.data <= s_axi_wdata;
        wreq_q.strb <= s_axi_wstrb;
      end
      if (wr_o) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_err_i ? `LCDC_RESP_SLVERR : `LCDC_RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel: register the data one cycle after the address
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= `LCDC_RESP_OKAY;
      rdata_q <= `LCDC_RESET_WORD;
    end else if (rd_o) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_err_i ? `LCDC_RESP_SLVERR : `LCDC_RESP_OKAY;
      rdata_q <= rd_data_i;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule // lcdc_axil_slave

// ===== design/lcdc_top.sv
// Purpose: Control and event logic around an analog level crossing comparator
// Assumes: cmp_above_i is already synchronous to clk_i; registers over AXI4-Lite
// Notes:   Startup wait is a parameter so simulation can shorten it
//
// Summary of operation
// - Enabled unit runs between start and stop
// - Ready event after startup interval elapses
// - Crossing event each time inputs cross
// - Up on upward crossing, down on downward
// - Any-crossing event on every crossing too
// - Sample task copies live output to outcome unless idle
// - Differential or single-ended, three speed settings
// - Positive input chosen by select register
// - Differential band applied around negative input
// - Ladder switches lower while above, upper below
// - Upper and lower codes from ladder register
// - Band enable ignored in single-ended mode
// - Pin reference uses outside pin select
// - Event flags at 0x100 through 0x10c
// - Mask at 0x300, set 0x304, clear 0x308
// - Link register at 0x200 chains events to tasks
// - Single instance decoded at base 0x40013000
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module lcdc_top
  import lcdc_pkg::*;
#(
  parameter int unsigned STARTUP_NS = `LCDC_T_START_NS
)(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmp_above_i,
  output lcdc_ana_ctl_t ana_ctl_o,
  output logic irq_o
);
  `include "lcdc_map.svh"

  // ----------------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------------
  // Least wait, rounded up to whole cycles, never below one
  localparam int unsigned START_CYC_RAW = (STARTUP_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS;
  localparam int unsigned START_CYC = (START_CYC_RAW < 1) ? 1 : START_CYC_RAW;
  localparam int unsigned EV_READY = 0; // Flag and mask bit of each event
  localparam int unsigned EV_DOWN = 1;
  localparam int unsigned EV_UP = 2;
  localparam int unsigned EV_CROSS = 3;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  // True when an address falls on a mapped register of this instance
  function automatic logic lcdc_mapped(input logic [31:0] a);
    logic hit;
    hit = 1'b0;
    if ((a & `LCDC_BASE_MASK) == `LCDC_BASE && a[1:0] == 2'h0) begin
      case (a[11:0])
        `LCDC_OFS_BEGIN, `LCDC_OFS_HALT, `LCDC_OFS_CAPTURE,
        `LCDC_OFS_VALID, `LCDC_OFS_FALLING, `LCDC_OFS_RISING,
        `LCDC_OFS_ANYCROSS, `LCDC_OFS_LINKS, `LCDC_OFS_MASK,
        `LCDC_OFS_MASK_SET, `LCDC_OFS_MASK_CLR, `LCDC_OFS_OUTCOME,
        `LCDC_OFS_ENABLE, `LCDC_OFS_PSEL, `LCDC_OFS_REFSRC,
        `LCDC_OFS_REFPIN, `LCDC_OFS_LADDER, `LCDC_OFS_CONFIG,
        `LCDC_OFS_BAND: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lcdc_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  lcdc_wreq_t wreq; // Write request from the slave
  logic wr; // One-cycle write strobe
  logic rd; // One-cycle read strobe
  logic [31:0] rd_data; // Read mux output
  logic wr_hit; // Write lands on a mapped register
  logic [11:0] wofs; // Write offset within the instance

  lcdc_axil_slave u_slave (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wreq_o(wreq),
    .wr_o(wr),
    .wr_err_i(!wr_hit),
    .rd_o(rd),
    .rd_data_i(rd_data),
    .rd_err_i(!lcdc_mapped(s_axi_araddr))
  );

  assign wr_hit = lcdc_mapped(wreq.addr);
  assign wofs = wreq.addr[11:0];

  // Write strobe for one offset, only on a mapped hit
  function automatic logic wr_to(input logic [11:0] ofs, input logic w,
                                 input logic h, input logic [11:0] cur);
    return w && h && (cur == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [1:0] enable_q; // Unit enable field
  logic [2:0] psel_q; // Positive input select
  logic [2:0] refsrc_q; // Ladder reference source
  logic [2:0] refpin_q; // Outside reference pin
  logic [5:0] up_code_q; // upper_level_code
  logic [5:0] down_code_q; // lower_level_code
  logic [1:0] speed_q; // Low-power, normal, high-speed
  logic main_se_q; // 1 selects single-ended
  logic band_q; // diff_band_enable
  logic [4:0] links_q; // event_task_links
  logic [3:0] mask_q; // irq_mask
  logic [31:0] ladder_w; // Merged ladder word
  logic [31:0] config_w; // Merged config word
  logic unit_on; // Unit is enabled

  assign ladder_w = lcdc_merge({18'h0, up_code_q, 2'h0, down_code_q}, wreq.data, wreq.strb);
  assign config_w = lcdc_merge({23'h0, main_se_q, 6'h0, speed_q}, wreq.data, wreq.strb);
  assign unit_on = (enable_q == `LCDC_ENABLE_ON);

  // Plain configuration storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      enable_q <= 2'h0;
      psel_q <= 3'h0;
      refsrc_q <= 3'h0;
      refpin_q <= 3'h0;
      up_code_q <= 6'h0;
      down_code_q <= 6'h0;
      speed_q <= 2'h0;
      main_se_q <= 1'b0;
      band_q <= 1'b0;
      links_q <= 5'h0;
    end else begin
      if (wr_to(`LCDC_OFS_ENABLE, wr, wr_hit, wofs) && wreq.strb[0]) begin
        enable_q <= wreq.data[1:0];
      end
      if (wr_to(`LCDC_OFS_PSEL, wr, wr_hit, wofs) && wreq.strb[0]) begin
        psel_q <= wreq.data[2:0];
      end
      if (wr_to(`LCDC_OFS_REFSRC, wr, wr_hit, wofs) && wreq.strb[0]) begin
        refsrc_q <= wreq.data[2:0];
      end
      if (wr_to(`LCDC_OFS_REFPIN, wr, wr_hit, wofs) && wreq.strb[0]) begin
        refpin_q <= wreq.data[2:0];
      end
      if (wr_to(`LCDC_OFS_LADDER, wr, wr_hit, wofs)) begin
        up_code_q <= ladder_w[`LCDC_LADDER_UP_LSB +: 6];
        down_code_q <= ladder_w[5:0];
      end
      if (wr_to(`LCDC_OFS_CONFIG, wr, wr_hit, wofs)) begin
        speed_q <= config_w[1:0];
        main_se_q <= config_w[`LCDC_CONFIG_MAIN_BIT];
      end
      if (wr_to(`LCDC_OFS_BAND, wr, wr_hit, wofs) && wreq.strb[0]) begin
        band_q <= wreq.data[0];
      end
      if (wr_to(`LCDC_OFS_LINKS, wr, wr_hit, wofs) && wreq.strb[0]) begin
        links_q <= wreq.data[4:0];
      end
    end
  end

  // Mask: direct write, set-only and clear-only companions
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_q <= 4'h0;
    end else if (wreq.strb[0]) begin
      if (wr_to(`LCDC_OFS_MASK, wr, wr_hit, wofs)) begin
        mask_q <= wreq.data[3:0];
      end else if (wr_to(`LCDC_OFS_MASK_SET, wr, wr_hit, wofs)) begin
        mask_q <= mask_q | wreq.data[3:0];
      end else if (wr_to(`LCDC_OFS_MASK_CLR, wr, wr_hit, wofs)) begin
        mask_q <= mask_q & ~wreq.data[3:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Tasks, run control and events
  // ----------------------------------------------------------------------
  logic [3:0] ev; // One-cycle event pulses
  logic t_start; // Start task this cycle
  logic t_halt_sw; // Software stop write this cycle
  logic t_stop; // Stop task this cycle
  logic t_sample; // Sample task this cycle
  lcdc_state_t state_q;
  logic [31:0] wait_q; // Startup countdown
  logic prev_q; // Output level seen last cycle, in any run state
  logic outcome_q; // Captured result
  logic [3:0] flag_q; // Sticky event flags

  // Software writes of 1 pulse a task; chained events add to the stop and sample tasks
  assign t_start = wr_to(`LCDC_OFS_BEGIN, wr, wr_hit, wofs) && wreq.data[0];
  assign t_halt_sw = wr_to(`LCDC_OFS_HALT, wr, wr_hit, wofs) && wreq.data[0];
  assign t_stop = t_halt_sw
                  || (links_q[1] && ev[EV_READY]) || (links_q[2] && ev[EV_DOWN])
                  || (links_q[3] && ev[EV_UP]) || (links_q[4] && ev[EV_CROSS]);
  assign t_sample = (wr_to(`LCDC_OFS_CAPTURE, wr, wr_hit, wofs) && wreq.data[0])
                    || (links_q[0] && ev[EV_READY]);

  // Run state: stop wins over start; disabling the unit also halts it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= LCDC_IDLE;
      wait_q <= 32'h0;
    end else if (!unit_on || t_stop) begin
      state_q <= LCDC_IDLE;
    end else begin
      case (state_q)
        LCDC_IDLE: begin
          if (t_start) begin
            state_q <= LCDC_STARTING;
            wait_q <= 32'(START_CYC - 1);
          end
        end
        LCDC_STARTING: begin
          if (wait_q == 32'h0) begin
            state_q <= LCDC_RUNNING;
          end else begin
            wait_q <= wait_q - 32'h1;
          end
        end
        LCDC_RUNNING: state_q <= LCDC_RUNNING;
        default: state_q <= LCDC_IDLE;
      endcase
    end
  end

  // Track the last level every cycle, whatever the run state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= cmp_above_i;
    end
  end

  // Event pulses
  always_comb begin
    ev = 4'h0;
    // Only a software stop suppresses ready; a linked stop would loop back here
    ev[EV_READY] = (state_q == LCDC_STARTING) && (wait_q == 32'h0)
                   && unit_on && !t_halt_sw;
    if (state_q == LCDC_RUNNING) begin
      ev[EV_UP] = cmp_above_i && !prev_q;
      ev[EV_DOWN] = !cmp_above_i && prev_q;
      ev[EV_CROSS] = cmp_above_i != prev_q;
    end
  end

  // Sticky flags: hardware set wins over a software write
  generate
    for (genvar g = 0; g < 4; g++) begin : g_flag
      logic wr_flag;
      assign wr_flag = wr_to(`LCDC_OFS_VALID + 12'(4 * g), wr, wr_hit, wofs) && wreq.strb[0];
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          flag_q[g] <= 1'b0;
        end else if (ev[g]) begin
          flag_q[g] <= 1'b1;
        end else if (wr_flag) begin
          flag_q[g] <= wreq.data[0];
        end
      end
    end
  endgenerate

  // Sample task captures the live comparator output unless idle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      outcome_q <= 1'b0;
    end else if (t_sample && state_q != LCDC_IDLE) begin
      outcome_q <= cmp_above_i;
    end
  end

  // Interrupt line follows any set flag that is unmasked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flag_q & mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ana_ctl_o <= '0;
    end else begin
      ana_ctl_o.powered <= unit_on && (state_q != LCDC_IDLE);
      ana_ctl_o.pos_sel <= psel_q;
      ana_ctl_o.ref_src <= refsrc_q;
      ana_ctl_o.ref_pin <= refpin_q;
      ana_ctl_o.single_ended <= main_se_q;
      ana_ctl_o.speed <= speed_q;
      ana_ctl_o.band_en <= band_q && !main_se_q;
      // Above selects the lower level, below the upper level
      ana_ctl_o.ladder_code <= cmp_above_i ? down_code_q : up_code_q;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    rd_data = `LCDC_RESET_WORD;
    if (lcdc_mapped(s_axi_araddr)) begin
      case (s_axi_araddr[11:0])
        `LCDC_OFS_VALID: rd_data[0] = flag_q[EV_READY];
        `LCDC_OFS_FALLING: rd_data[0] = flag_q[EV_DOWN];
        `LCDC_OFS_RISING: rd_data[0] = flag_q[EV_UP];
        `LCDC_OFS_ANYCROSS: rd_data[0] = flag_q[EV_CROSS];
        `LCDC_OFS_LINKS: rd_data[4:0] = links_q;
        `LCDC_OFS_MASK, `LCDC_OFS_MASK_SET, `LCDC_OFS_MASK_CLR: rd_data[3:0] = mask_q;
        `LCDC_OFS_OUTCOME: rd_data[0] = outcome_q;
        `LCDC_OFS_ENABLE: rd_data[1:0] = enable_q;
        `LCDC_OFS_PSEL: rd_data[2:0] = psel_q;
        `LCDC_OFS_REFSRC: rd_data[2:0] = refsrc_q;
        `LCDC_OFS_REFPIN: rd_data[2:0] = refpin_q;
        `LCDC_OFS_LADDER: rd_data[13:0] = {up_code_q, 2'h0, down_code_q};
        `LCDC_OFS_CONFIG: rd_data[8:0] = {main_se_q, 6'h0, speed_q};
        `LCDC_OFS_BAND: rd_data[0] = band_q;
        default: rd_data = `LCDC_RESET_WORD; // Tasks read as zero
      endcase
    end
  end
endmodule // lcdc_top

// ===== testbench/lcdc_properties.sv
// Purpose: Port checks for the crossing detector bus side
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to lcdc_top
`timescale 1ns/1ps
module lcdc_properties #(
  parameter int unsigned STARTUP_NS = 1000
)(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------------------------------
  // Handshake timing and response checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped");
  property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("arready with rvalid");
  property p_w_blk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_w_blk: assert property (p_w_blk) else $error("ready with bvalid");
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read late");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write late");
  property p_err_zero; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error data");
  property p_bcode; s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}; endproperty
  a_bcode: assert property (p_bcode) else $error("bad bresp");
endmodule // lcdc_properties
bind lcdc_top lcdc_properties #(.STARTUP_NS(STARTUP_NS)) u_props (.*);

// ===== testbench/lcdc_analog_model.sv
// Purpose: Comparator core seen from the pins
// Assumes: Levels are ladder steps
// Notes:   Reads low while unpowered
`timescale 1ns/1ps
module lcdc_analog_model
  import lcdc_pkg::*;
(
  input wire logic clk_i,
  input wire lcdc_ana_ctl_t ctl_i,
  input wire logic [5:0] pos_lvl_i,
  input wire logic [5:0] neg_lvl_i,
  output logic above_o
);
  logic above_q = 1'b0; // Settled comparator output
  // Compare positive input against ladder or second pin
  always_ff @(posedge clk_i) begin
    if (!ctl_i.powered) begin
      above_q <= 1'b0;
    end else if (ctl_i.single_ended) begin
      above_q <= pos_lvl_i > ctl_i.ladder_code;
    end else begin
      above_q <= pos_lvl_i > neg_lvl_i;
    end
  end
  assign above_o = above_q;
endmodule // lcdc_analog_model

// ===== testbench/tb_top.sv
// Purpose: Self-checking bench for the crossing detector
// Assumes: Startup shortened to one cycle
// Notes:   AXI4-Lite master tasks
`timescale 1ns/1ps
`include "lcdc_map.svh"
module tb_top
  import lcdc_pkg::*;
;
  logic clk_i = 1'b0, sys_rst_i = 1'b1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic awr, wr_, bv, arr, rv, irq, cmp;
  logic [1:0] br, rr, r;
  logic [31:0] awa = 0, wd = 0, ara = 0, rd_, d, base = `LCDC_BASE;
  logic [5:0] pos = 6'h18, neg = 6'h20;
  lcdc_ana_ctl_t ctl;
  int failures = 0, tests_run = 0;
  lcdc_top #(.STARTUP_NS(40)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .cmp_above_i(cmp), .ana_ctl_o(ctl), .irq_o(irq));
  lcdc_analog_model u_ana (.clk_i(clk_i), .ctl_i(ctl), .pos_lvl_i(pos), .neg_lvl_i(neg),
    .above_o(cmp));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // AXI write, both halves offered together
  task wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk_i);
    awa <= base + a; wd <= v; awv <= 1; wv <= 1; bre <= 1;
    do begin
      @(negedge clk_i); ta = awv && awr; tw = wv && wr_; tb = bv; r = br;
      @(posedge clk_i); if (ta) awv <= 0; if (tw) wv <= 0;
    end while (!tb);
    bre <= 0;
  endtask
  // AXI read
  task rd(input logic [11:0] a);
    logic ta, tr;
    @(posedge clk_i);
    ara <= base + a; arv <= 1; rre <= 1;
    do begin
      @(negedge clk_i); ta = arv && arr; tr = rv; d = rd_; r = rr;
      @(posedge clk_i); if (ta) arv <= 0;
    end while (!tr);
    rre <= 0;
  endtask
  task rdc(input string n, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a); chk(n, e, d & m);
  endtask
  task settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task clr_flags();
    for (int i = 0; i < 4; i++) wr(12'h100 + 12'(4 * i), 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs();
    rdc("ladder_rst", `LCDC_OFS_LADDER, 0, 32'hffffffff);
    wr(`LCDC_OFS_LADDER, 32'h2010); rdc("ladder", `LCDC_OFS_LADDER, 32'h2010, 32'h3f3f);
    for (int s = 0; s < 3; s++) begin
      wr(`LCDC_OFS_CONFIG, 32'h100 | s); settle(2);
      chk("speed", 32'h4 | s, {ctl.single_ended, ctl.speed});
      chk("speed_nosel", s, {1'b1, ctl.speed} & 3);
    end
    wr(12'h600, 1); chk("unmapped_b", 2, r);
    rdc("unmapped_r", 12'h600, 0, 32'hffffffff); chk("unmapped_rr", 2, r);
    base = 32'h4001_4000; rd(`LCDC_OFS_LADDER); chk("far_base", 2, r);
    base = `LCDC_BASE;
    wr(`LCDC_OFS_MASK_SET, 32'hf); wr(`LCDC_OFS_MASK_CLR, 32'h2);
    rdc("mask", `LCDC_OFS_MASK, 32'hd, 32'hf);
    wr(`LCDC_OFS_MASK, 32'hf);
    $display("t_regs done");
  endtask
  task t_detect();
    wr(`LCDC_OFS_PSEL, 3); wr(`LCDC_OFS_REFSRC, 4); wr(`LCDC_OFS_REFPIN, 5);
    wr(`LCDC_OFS_BAND, 1); wr(`LCDC_OFS_ENABLE, 2); wr(`LCDC_OFS_BEGIN, 1);
    chk("psel", 3, ctl.pos_sel); chk("refsrc", 4, ctl.ref_src);
    chk("refpin", 5, ctl.ref_pin); chk("band_se", 0, ctl.band_en);
    rdc("ready", `LCDC_OFS_VALID, 1, 1); chk("irq_on", 1, irq);
    clr_flags(); settle(3); chk("irq_off", 0, irq); chk("upper", 6'h20, ctl.ladder_code);
    pos = 6'h28; settle(4);
    rdc("up", `LCDC_OFS_RISING, 1, 1); rdc("any_up", `LCDC_OFS_ANYCROSS, 1, 1);
    rdc("no_down", `LCDC_OFS_FALLING, 0, 1); chk("lower", 6'h10, ctl.ladder_code);
    pos = 6'h18; settle(4); wr(`LCDC_OFS_CAPTURE, 1);
    rdc("held_above", `LCDC_OFS_OUTCOME, 1, 1); clr_flags();
    pos = 6'h08; settle(4);
    rdc("down", `LCDC_OFS_FALLING, 1, 1); rdc("any_dn", `LCDC_OFS_ANYCROSS, 1, 1);
    rdc("no_up", `LCDC_OFS_RISING, 0, 1);
    wr(`LCDC_OFS_HALT, 1); settle(2); chk("halted", 0, ctl.powered);
    $display("t_detect done");
  endtask
  task t_links();
    clr_flags(); wr(`LCDC_OFS_LINKS, 32'h8); wr(`LCDC_OFS_ENABLE, 0);
    wr(`LCDC_OFS_CONFIG, 0); wr(`LCDC_OFS_PSEL, 3); wr(`LCDC_OFS_REFPIN, 5);
    wr(`LCDC_OFS_ENABLE, 2); wr(`LCDC_OFS_BEGIN, 1); settle(4);
    chk("band_diff", 1, ctl.band_en);
    pos = 6'h28; settle(6);
    rdc("link_up", `LCDC_OFS_RISING, 1, 1); chk("link_stop", 0, ctl.powered);
    pos = 6'h08; settle(6); rdc("stopped", `LCDC_OFS_FALLING, 0, 1);
    $display("t_links done");
  endtask
  task final_report();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 0;
    t_regs(); t_detect(); t_links();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    final_report();
  end
endmodule // tb_top
